// [src/lom_consts.vh]
/*
  Constants for the link OAM event monitor: register offsets, control
  field positions, reset values of the configuration and timing counts.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef LOM_CONSTS_VH
`define LOM_CONSTS_VH

////////////////////////////////////////////////////////////////////////////
// timing
`define LOM_CLK_NS        10
`define LOM_TICK_NS       100000000
`define LOM_TICK_CYC      (`LOM_TICK_NS / `LOM_CLK_NS)
`define LOM_TICKS_PER_SEC 4'ha

////////////////////////////////////////////////////////////////////////////
// configuration registers (byte addresses)
`define LOM_A_FE_WIN      8'h00
`define LOM_A_FE_THR      8'h04
`define LOM_A_FP_WIN      8'h08
`define LOM_A_FP_THR      8'h0c
`define LOM_A_SP_WIN_LO   8'h10
`define LOM_A_SP_WIN_HI   8'h14
`define LOM_A_SP_THR_LO   8'h18
`define LOM_A_SP_THR_HI   8'h1c
`define LOM_A_ES_WIN      8'h20
`define LOM_A_ES_THR      8'h24
`define LOM_A_CTRL        8'h28

// status registers, read only
`define LOM_A_REM_SEQ     8'h40
`define LOM_A_FE_TS       8'h44
`define LOM_A_FE_CNT      8'h48
`define LOM_A_FE_TOT_LO   8'h4c
`define LOM_A_FE_TOT_HI   8'h50
`define LOM_A_FE_EVN      8'h54
`define LOM_A_FP_TS       8'h58
`define LOM_A_FP_CNT      8'h5c
`define LOM_A_FP_TOT_LO   8'h60
`define LOM_A_FP_TOT_HI   8'h64
`define LOM_A_FP_EVN      8'h68
`define LOM_A_SP_TS       8'h6c
`define LOM_A_SP_CNT_LO   8'h70
`define LOM_A_SP_CNT_HI   8'h74
`define LOM_A_SP_TOT_LO   8'h78
`define LOM_A_SP_TOT_HI   8'h7c
`define LOM_A_SP_EVN      8'h80
`define LOM_A_ES_TS       8'h84
`define LOM_A_ES_CNT      8'h88
`define LOM_A_ES_TOT      8'h8c
`define LOM_A_ES_EVN      8'h90

////////////////////////////////////////////////////////////////////////////
// control fields
`define LOM_CTRL_EN       0
`define LOM_CTRL_CLR      1

////////////////////////////////////////////////////////////////////////////
// reset values and window bounds
`define LOM_FE_WIN_RST    16'h000a
`define LOM_FE_WIN_MIN    16'h000a
`define LOM_FE_WIN_MAX    16'h0258
`define LOM_FE_THR_RST    32'h00000001
`define LOM_FP_WIN_RST    32'h000003e8
`define LOM_FP_THR_RST    32'h00000001
`define LOM_SP_WIN_RST    64'h0000000005f5e100
`define LOM_SP_THR_RST    64'h0000000000000001
`define LOM_ES_WIN_RST    16'h0258
`define LOM_ES_THR_RST    16'h0001
`define LOM_CTRL_EN_RST   1'b1

`endif

// [src/lom_tick.v]
/*
  Timebase of the event monitor: a 100 ms tick pulse, a one second pulse
  made from whole ticks, and a 16-bit running tick count used as stamp.
  Assumes one clock and a synchronous clear from the OAM sublayer reset.
*/
`timescale 1ns/1ns
`include "lom_consts.vh"

module lom_tick #(
  parameter [31:0] CYC = `LOM_TICK_CYC
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        clr,
  output reg         tick_q,
  output reg         sec_q,
  output reg  [15:0] stamp_q
);

  reg  [31:0] div_q;
  reg  [3:0]  sub_q;
  wire        wrap;

  // the divider end; a CYC of zero behaves as one
  assign wrap = (div_q + 32'h00000001 >= CYC);

  ////////////////////////////////////////////////////////////////////////
  // divider, ticks within the second and the stamp counter
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q   <= 32'h00000000;
      sub_q   <= 4'h0;
      tick_q  <= 1'b0;
      sec_q   <= 1'b0;
      stamp_q <= 16'h0000;
    end else if (clr) begin
      div_q   <= 32'h00000000;
      sub_q   <= 4'h0;
      tick_q  <= 1'b0;
      sec_q   <= 1'b0;
      stamp_q <= 16'h0000;
    end else begin
      tick_q <= 1'b0;
      sec_q  <= 1'b0;
      if (wrap) begin
        div_q   <= 32'h00000000;
        tick_q  <= 1'b1;
        stamp_q <= stamp_q + 16'h0001; // wraps after 6553.6 s by design
        if (sub_q == `LOM_TICKS_PER_SEC - 4'h1) begin
          sub_q <= 4'h0;
          sec_q <= 1'b1;
        end else begin
          sub_q <= sub_q + 4'h1;
        end
      end else begin
        div_q <= div_q + 32'h00000001;
      end
    end
  end

endmodule

// [src/lom_mon.v]
/*
  One link event monitor: counts errors over a window of units, tests the
  period count against a threshold when the window closes, and keeps the
  cumulative error total, the event total and the last event stamp.
  Assumes err and adv are single-cycle pulses on the same clock.
*/
`timescale 1ns/1ns

module lom_mon #(
  parameter WW = 16,
  parameter CW = 32,
  parameter TW = 64
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          clr,
  input  wire          adv,
  input  wire          err,
  input  wire [WW-1:0] win,
  input  wire [CW-1:0] thr,
  input  wire [15:0]   stamp,
  output reg  [CW-1:0] cnt_q,
  output reg  [TW-1:0] tot_q,
  output reg  [31:0]   evn_q,
  output reg  [15:0]   ts_q,
  output reg           evt_q
);

  reg  [WW-1:0] pos_q;
  wire [WW-1:0] pos_nx;
  wire [CW-1:0] cnt_now;
  wire          last;

  // period count saturates so a wrap can never hide a crossing
  assign cnt_now = (err && cnt_q != {CW{1'b1}}) ? cnt_q + 1'b1 : cnt_q;
  assign pos_nx  = pos_q + 1'b1;
  // a window of zero closes on every unit
  assign last    = adv && (pos_nx >= win);

  ////////////////////////////////////////////////////////////////////////
  // window position, period count, totals and event capture
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= {WW{1'b0}};
      cnt_q <= {CW{1'b0}};
      tot_q <= {TW{1'b0}};
      evn_q <= 32'h00000000;
      ts_q  <= 16'h0000;
      evt_q <= 1'b0;
    end else if (clr) begin
      pos_q <= {WW{1'b0}};
      cnt_q <= {CW{1'b0}};
      tot_q <= {TW{1'b0}};
      evn_q <= 32'h00000000;
      ts_q  <= 16'h0000;
      evt_q <= 1'b0;
    end else begin
      evt_q <= 1'b0;
      if (err) begin
        tot_q <= tot_q + 1'b1;
      end
      if (last) begin
        pos_q <= {WW{1'b0}};
        cnt_q <= {CW{1'b0}};
        if (cnt_now >= thr) begin
          evt_q <= 1'b1;
          evn_q <= evn_q + 32'h00000001;
          ts_q  <= stamp;
        end
      end else begin
        if (adv) begin
          pos_q <= pos_nx;
        end
        cnt_q <= cnt_now;
      end
    end
  end

endmodule

// [src/lom_top.v]
/*
  Link OAM link event monitor for one port: an APB register slave, the
  100 ms timebase and four event monitors (errored frames per time,
  errored frames per frame count, errored symbols per symbol count and
  errored frame seconds per time), plus the remote sequence number.
  Assumes all link-side strobes come from MAC/PCS logic on CLOCK.
  // What this block does
  // - keep 16-bit remote event sequence number
  // - stamp each event with 16-bit 100 ms ticks
  // - frame window 16 bits, 1 s default, 1..60 s
  // - frame threshold 32 bits, default one, zero allowed
  // - event only when count reaches threshold
  // - hold 32-bit errored frames in current window
  // - keep 64-bit errored frame total since reset
  // - count errored frame events, 32 bits
  // - frame period window counts frames, 32 bits
  // - frame period threshold 32-bit errored frames
  // - hold 32-bit frame errors in current period
  // - keep 64-bit frame period error total
  // - count frame period events, 32 bits
  // - symbol period window 64-bit symbol count
  // - symbol period threshold 64-bit errored symbols
  // - hold 64-bit symbol errors in current period
  // - keep 64-bit symbol error total since reset
  // - count symbol period events, 32 bits
  // - seconds summary window 16 bits, 100 ms units
  // - seconds threshold and period count 16 bits
  // - keep 32-bit errored seconds total
  // - count seconds summary events, 32 bits
*/
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "lom_consts.vh"

module lom_top #(
  parameter [31:0] TICK_CYC = `LOM_TICK_CYC
) (
  input  wire        CLOCK,
  input  wire        RST_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        FRAME_RX,
  input  wire        FRAME_ERR,
  input  wire        SYM_RX,
  input  wire        SYM_ERR,
  input  wire        OAM_RST,
  input  wire        REM_SEQ_VLD,
  input  wire [15:0] REM_SEQ,
  output reg         EVT_FRAME,
  output reg         EVT_PERIOD,
  output reg         EVT_SYMBOL,
  output reg         EVT_SECONDS
);

  ////////////////////////////////////////////////////////////////////////
  // configuration and control state
  reg  [15:0] fe_win_q;
  reg  [31:0] fe_thr_q;
  reg  [31:0] fp_win_q;
  reg  [31:0] fp_thr_q;
  reg  [63:0] sp_win_q;
  reg  [63:0] sp_thr_q;
  reg  [15:0] es_win_q;
  reg  [15:0] es_thr_q;
  reg         en_q;
  reg         clr_q;
  reg  [15:0] rem_seq_q;
  reg         es_seen_q;

  wire        tick;
  wire        sec;
  wire [15:0] stamp;

  wire [31:0] fe_cnt;
  wire [63:0] fe_tot;
  wire [31:0] fe_evn;
  wire [15:0] fe_ts;
  wire        fe_evt;
  wire [31:0] fp_cnt;
  wire [63:0] fp_tot;
  wire [31:0] fp_evn;
  wire [15:0] fp_ts;
  wire        fp_evt;
  wire [63:0] sp_cnt;
  wire [63:0] sp_tot;
  wire [31:0] sp_evn;
  wire [15:0] sp_ts;
  wire        sp_evt;
  wire [15:0] es_cnt;
  wire [31:0] es_tot;
  wire [31:0] es_evn;
  wire [15:0] es_ts;
  wire        es_evt;
  wire        es_err;

  wire        wr_acc;
  reg  [31:0] rd_d;
  reg         err_d;

  // a write lands only at the access edge the slave marked ready
  assign wr_acc = PSEL & PENABLE & PWRITE & PREADY;

  // window bounds are enforced on write so logic never sees a bad value
  function [15:0] fe_clamp;
    input [31:0] v;
    begin
      if (v < {16'h0000, `LOM_FE_WIN_MIN}) begin
        fe_clamp = `LOM_FE_WIN_MIN;
      end else if (v > {16'h0000, `LOM_FE_WIN_MAX}) begin
        fe_clamp = `LOM_FE_WIN_MAX;
      end else begin
        fe_clamp = v[15:0];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // configuration writes and the sublayer clear pulse
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      fe_win_q <= `LOM_FE_WIN_RST;
      fe_thr_q <= `LOM_FE_THR_RST;
      fp_win_q <= `LOM_FP_WIN_RST;
      fp_thr_q <= `LOM_FP_THR_RST;
      sp_win_q <= `LOM_SP_WIN_RST;
      sp_thr_q <= `LOM_SP_THR_RST;
      es_win_q <= `LOM_ES_WIN_RST;
      es_thr_q <= `LOM_ES_THR_RST;
      en_q     <= `LOM_CTRL_EN_RST;
      clr_q    <= 1'b0;
    end else begin
      clr_q <= OAM_RST;
      if (wr_acc) begin
        case (PADDR)
          `LOM_A_FE_WIN:    fe_win_q <= fe_clamp(PWDATA);
          `LOM_A_FE_THR:    fe_thr_q <= PWDATA;
          `LOM_A_FP_WIN:    fp_win_q <= PWDATA;
          `LOM_A_FP_THR:    fp_thr_q <= PWDATA;
          `LOM_A_SP_WIN_LO: sp_win_q[31:0]  <= PWDATA;
          `LOM_A_SP_WIN_HI: sp_win_q[63:32] <= PWDATA;
          `LOM_A_SP_THR_LO: sp_thr_q[31:0]  <= PWDATA;
          `LOM_A_SP_THR_HI: sp_thr_q[63:32] <= PWDATA;
          `LOM_A_ES_WIN:    es_win_q <= PWDATA[15:0];
          `LOM_A_ES_THR:    es_thr_q <= PWDATA[15:0];
          `LOM_A_CTRL: begin
            en_q  <= PWDATA[`LOM_CTRL_EN];
            clr_q <= OAM_RST | PWDATA[`LOM_CTRL_CLR];
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // remote sequence number and errored-second detection
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rem_seq_q <= 16'h0000;
      es_seen_q <= 1'b0;
    end else if (clr_q) begin
      rem_seq_q <= 16'h0000;
      es_seen_q <= 1'b0;
    end else begin
      if (REM_SEQ_VLD) begin
        rem_seq_q <= REM_SEQ;
      end
      // a frame error in the closing cycle still marks that second
      if (sec) begin
        es_seen_q <= 1'b0;
      end else if (en_q && FRAME_ERR) begin
        es_seen_q <= 1'b1;
      end
    end
  end

  // gated by enable too, so a second that closes while disabled is lost
  assign es_err = en_q & sec & (es_seen_q | FRAME_ERR);

  ////////////////////////////////////////////////////////////////////////
  // timebase and the four monitors
  lom_tick #(
    .CYC (TICK_CYC)
  ) u_tick (
    .clk     (CLOCK),
    .rst_n   (RST_N),
    .clr     (clr_q),
    .tick_q  (tick),
    .sec_q   (sec),
    .stamp_q (stamp)
  );

  // errored frames over a time window of ticks
  lom_mon #(.WW(16), .CW(32), .TW(64)) u_fe (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .clr   (clr_q),
    .adv   (tick & en_q),
    .err   (FRAME_ERR & en_q),
    .win   (fe_win_q),
    .thr   (fe_thr_q),
    .stamp (stamp),
    .cnt_q (fe_cnt),
    .tot_q (fe_tot),
    .evn_q (fe_evn),
    .ts_q  (fe_ts),
    .evt_q (fe_evt)
  );

  // errored frames over a window of received frames
  lom_mon #(.WW(32), .CW(32), .TW(64)) u_fp (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .clr   (clr_q),
    .adv   (FRAME_RX & en_q),
    .err   (FRAME_ERR & en_q),
    .win   (fp_win_q),
    .thr   (fp_thr_q),
    .stamp (stamp),
    .cnt_q (fp_cnt),
    .tot_q (fp_tot),
    .evn_q (fp_evn),
    .ts_q  (fp_ts),
    .evt_q (fp_evt)
  );

  // errored symbols over a window of received symbols
  lom_mon #(.WW(64), .CW(64), .TW(64)) u_sp (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .clr   (clr_q),
    .adv   (SYM_RX & en_q),
    .err   (SYM_ERR & en_q),
    .win   (sp_win_q),
    .thr   (sp_thr_q),
    .stamp (stamp),
    .cnt_q (sp_cnt),
    .tot_q (sp_tot),
    .evn_q (sp_evn),
    .ts_q  (sp_ts),
    .evt_q (sp_evt)
  );

  // errored seconds over a time window of ticks
  lom_mon #(.WW(16), .CW(16), .TW(32)) u_es (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .clr   (clr_q),
    .adv   (tick & en_q),
    .err   (es_err),
    .win   (es_win_q),
    .thr   (es_thr_q),
    .stamp (stamp),
    .cnt_q (es_cnt),
    .tot_q (es_tot),
    .evn_q (es_evn),
    .ts_q  (es_ts),
    .evt_q (es_evt)
  );

  ////////////////////////////////////////////////////////////////////////
  // read decode; unmapped addresses read zero and flag an error
  always @* begin
    rd_d  = 32'h00000000;
    err_d = 1'b0;
    case (PADDR)
      `LOM_A_FE_WIN:    rd_d = {16'h0000, fe_win_q};
      `LOM_A_FE_THR:    rd_d = fe_thr_q;
      `LOM_A_FP_WIN:    rd_d = fp_win_q;
      `LOM_A_FP_THR:    rd_d = fp_thr_q;
      `LOM_A_SP_WIN_LO: rd_d = sp_win_q[31:0];
      `LOM_A_SP_WIN_HI: rd_d = sp_win_q[63:32];
      `LOM_A_SP_THR_LO: rd_d = sp_thr_q[31:0];
      `LOM_A_SP_THR_HI: rd_d = sp_thr_q[63:32];
      `LOM_A_ES_WIN:    rd_d = {16'h0000, es_win_q};
      `LOM_A_ES_THR:    rd_d = {16'h0000, es_thr_q};
      `LOM_A_CTRL:      rd_d = {31'h0, en_q};
      `LOM_A_REM_SEQ:   rd_d = {16'h0000, rem_seq_q};
      `LOM_A_FE_TS:     rd_d = {16'h0000, fe_ts};
      `LOM_A_FE_CNT:    rd_d = fe_cnt;
      `LOM_A_FE_TOT_LO: rd_d = fe_tot[31:0];
      `LOM_A_FE_TOT_HI: rd_d = fe_tot[63:32];
      `LOM_A_FE_EVN:    rd_d = fe_evn;
      `LOM_A_FP_TS:     rd_d = {16'h0000, fp_ts};
      `LOM_A_FP_CNT:    rd_d = fp_cnt;
      `LOM_A_FP_TOT_LO: rd_d = fp_tot[31:0];
      `LOM_A_FP_TOT_HI: rd_d = fp_tot[63:32];
      `LOM_A_FP_EVN:    rd_d = fp_evn;
      `LOM_A_SP_TS:     rd_d = {16'h0000, sp_ts};
      `LOM_A_SP_CNT_LO: rd_d = sp_cnt[31:0];
      `LOM_A_SP_CNT_HI: rd_d = sp_cnt[63:32];
      `LOM_A_SP_TOT_LO: rd_d = sp_tot[31:0];
      `LOM_A_SP_TOT_HI: rd_d = sp_tot[63:32];
      `LOM_A_SP_EVN:    rd_d = sp_evn;
      `LOM_A_ES_TS:     rd_d = {16'h0000, es_ts};
      `LOM_A_ES_CNT:    rd_d = {16'h0000, es_cnt};
      `LOM_A_ES_TOT:    rd_d = es_tot;
      `LOM_A_ES_EVN:    rd_d = es_evn;
      default:          err_d = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // apb answer: ready one cycle after setup, data captured in setup,
  // so a 64-bit pair read lo then hi may straddle a carry (limitation)
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end else begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & err_d;
      if (PSEL && !PENABLE && !PWRITE) begin
        PRDATA <= rd_d;
      end else begin
        PRDATA <= 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event strobes out, registered once more at the boundary
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      EVT_FRAME   <= 1'b0;
      EVT_PERIOD  <= 1'b0;
      EVT_SYMBOL  <= 1'b0;
      EVT_SECONDS <= 1'b0;
    end else begin
      EVT_FRAME   <= fe_evt;
      EVT_PERIOD  <= fp_evt;
      EVT_SYMBOL  <= sp_evt;
      EVT_SECONDS <= es_evt;
    end
  end

endmodule

// [dv/lom_sva.sv]
/*
  Checker for the link event monitor top: bus answer timing and the
  timing of the event pulses against their causes at the strobe inputs.
  Assumes one clock and a bench TICK_CYC of at least 10 cycles.
*/
`timescale 1ns/1ns

module lom_sva (
  input wire        CLOCK,
  input wire        RST_N,
  input wire        PSEL,
  input wire        PENABLE,
  input wire [7:0]  PADDR,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  input wire        FRAME_RX,
  input wire        SYM_RX,
  input wire        OAM_RST,
  input wire        EVT_FRAME,
  input wire        EVT_PERIOD,
  input wire        EVT_SYMBOL,
  input wire        EVT_SECONDS
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  ////////////////////////////////////////////////////////////////////////
  // bus answer: zero wait states, data and error only with ready
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing after setup");
  a_ready_only_access: assert property (PREADY |-> $past(PSEL && !PENABLE))
    else $error("ready without a setup cycle");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error flag outside access");
  a_idle_rdata_zero: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data not cleared");
  a_mapped_no_err: assert property (PREADY && $past(PADDR) <= 8'h28
    && $past(PADDR[1:0]) == 2'h0 |-> !PSLVERR)
    else $error("error on a mapped address");

  ////////////////////////////////////////////////////////////////////////
  // events follow the unit that closes their window by two cycles
  a_period_cause: assert property (EVT_PERIOD |-> $past(FRAME_RX, 2))
    else $error("period event without closing frame");
  a_symbol_cause: assert property (EVT_SYMBOL |-> $past(SYM_RX, 2))
    else $error("symbol event without closing symbol");
  // the frame window is at least one second, so its events never touch
  a_frame_pulse: assert property (EVT_FRAME |=> !EVT_FRAME)
    else $error("frame event longer than one cycle");
  a_quiet_after_clr: assert property (OAM_RST |->
    ##3 (!EVT_FRAME && !EVT_SECONDS) [*8])
    else $error("time window event right after clear");

  cover property (EVT_FRAME);
  cover property (EVT_PERIOD);
  cover property (EVT_SYMBOL);
  cover property (PSLVERR);
endmodule

bind lom_top lom_sva u_sva (
  .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .FRAME_RX(FRAME_RX), .SYM_RX(SYM_RX), .OAM_RST(OAM_RST),
  .EVT_FRAME(EVT_FRAME), .EVT_PERIOD(EVT_PERIOD),
  .EVT_SYMBOL(EVT_SYMBOL), .EVT_SECONDS(EVT_SECONDS));

// [dv/lom_peer.sv]
/*
  Model of the remote link peer: frame and symbol strobes from the line
  and the remote event sequence number from the parsed PDUs.
  Assumes the bench calls its tasks from one process.
*/
`timescale 1ns/1ns

module lom_peer (
  output reg        frame_rx,
  output reg        frame_err,
  output reg        sym_rx,
  output reg        sym_err,
  output reg        seq_vld,
  output reg [15:0] seq,
  input  wire       clk
);
  reg [15:0] seq_cnt;

  // quiet line at time zero
  initial begin
    {frame_rx, frame_err, sym_rx, sym_err, seq_vld} = 5'h00;
    seq = 16'hffff;
    seq_cnt = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // n units one per strobe, first nerr errored; gap idle cycles slow it
  task pulses(input sel, input [7:0] n, input [7:0] nerr,
              input [3:0] gap);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(posedge clk);
        {frame_rx, frame_err} <= {!sel, !sel && i < nerr};
        {sym_rx, sym_err} <= {sel, sel && i < nerr};
        repeat (gap) begin
          @(posedge clk);
          {frame_rx, frame_err, sym_rx, sym_err} <= 4'h0;
        end
      end
      @(posedge clk);
      {frame_rx, frame_err, sym_rx, sym_err} <= 4'h0;
    end
  endtask

  // peer raised k more events; the value is only valid with its strobe
  task send_seq(input [15:0] k);
    begin
      seq_cnt = seq_cnt + k;
      @(posedge clk);
      seq <= seq_cnt;
      seq_vld <= 1'b1;
      @(posedge clk);
      seq <= ~seq_cnt;
      seq_vld <= 1'b0;
    end
  endtask
endmodule

// [dv/testbench.sv]
/*
  Self-checking bench of the link event monitor: register defaults from
  a table, then window, threshold, total and clear cases.
  Assumes TICK_CYC of 10, so one second is 100 clock cycles.
*/
`timescale 1ns/1ns

module testbench;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg         oam_rst = 1'b0;
  wire [31:0] prdata;
  wire        pready, pslverr, frame_rx, frame_err, sym_rx, sym_err;
  wire        seq_vld;
  wire [15:0] seq;
  wire [3:0]  evt;
  integer     fail_count = 0;
  integer     n_checks = 0;
  integer     cyc = 0;
  integer     ev_n [0:3];
  integer     i, k;
  reg  [31:0] rd;
  reg         er;
  // address beside its reset value
  reg  [39:0] rows [0:11] = '{40'h000000000a, 40'h0400000001,
    40'h08000003e8, 40'h0c00000001, 40'h1005f5e100, 40'h1400000000,
    40'h1800000001, 40'h1c00000000, 40'h2000000258, 40'h2400000001,
    40'h2800000001, 40'h4800000000};

  always #5 clk = ~clk;

  lom_top #(.TICK_CYC(32'd10)) u_lom_top (.CLOCK(clk), .RST_N(rst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .FRAME_RX(frame_rx), .FRAME_ERR(frame_err),
    .SYM_RX(sym_rx), .SYM_ERR(sym_err), .OAM_RST(oam_rst),
    .REM_SEQ_VLD(seq_vld), .REM_SEQ(seq), .EVT_FRAME(evt[0]),
    .EVT_PERIOD(evt[1]), .EVT_SYMBOL(evt[2]), .EVT_SECONDS(evt[3]));

  lom_peer u_lom_peer (.frame_rx(frame_rx), .frame_err(frame_err),
    .sym_rx(sym_rx), .sym_err(sym_err), .seq_vld(seq_vld), .seq(seq),
    .clk(clk));

  ////////////////////////////////////////////////////////////////////////
  // count event pulses; the hang limit is far above the planned run
  always @(posedge clk) begin
    for (k = 0; k < 4; k = k + 1)
      if (evt[k] === 1'b1) ev_n[k] = ev_n[k] + 1;
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      test_done;
    end
  end

  task test_done;
    begin
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  task check(input [63:0] seen, input [63:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // one transfer; request held until ready is sampled high
  // only the bench timeout ends the wait for ready
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
        @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
    end
  endtask

  task rdc(input [7:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      check(rd, exp);
    end
  endtask

  // control write (clear, enable) and fresh event counts
  task start(input [31:0] ctrl);
    begin
      apb(1'b1, 8'h28, ctrl);
      for (k = 0; k < 4; k = k + 1) ev_n[k] = 0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 12; i = i + 1)
      rdc(rows[i][39:32], rows[i][31:0]);
    $display("test reset values done");
    // window clamp, unmapped and read-only places, remote sequence
    apb(1'b1, 8'h00, 32'h5);
    rdc(8'h00, 32'h0000000a);
    apb(1'b1, 8'h00, 32'h300);
    rdc(8'h00, 32'h00000258);
    apb(1'b0, 8'hfc, 32'h0);
    check({er, rd}, {1'b1, 32'h0});
    apb(1'b1, 8'h48, 32'h55);
    rdc(8'h48, 32'h0);
    u_lom_peer.send_seq(16'h1);
    u_lom_peer.send_seq(16'h2);
    rdc(8'h40, 32'h3);
    $display("test access done");
    // frame period: one errored window, one clean window, then a clean one at threshold zero
    apb(1'b1, 8'h08, 32'h2);
    start(32'h3);
    u_lom_peer.pulses(1'b0, 8'd4, 8'd1, 4'd0);
    repeat (3) @(posedge clk);
    rdc(8'h5c, 32'h0);
    rdc(8'h60, 32'h1);
    rdc(8'h68, 32'h1);
    check(ev_n[1], 1);
    apb(1'b1, 8'h0c, 32'h0);
    u_lom_peer.pulses(1'b0, 8'd2, 8'd0, 4'd2);
    repeat (3) @(posedge clk);
    rdc(8'h68, 32'h2);
    $display("test frame period done");
    // symbol period: two of three errored, then one of three
    apb(1'b1, 8'h10, 32'h3);
    apb(1'b1, 8'h18, 32'h2);
    start(32'h3);
    u_lom_peer.pulses(1'b1, 8'd3, 8'd2, 4'd0);
    u_lom_peer.pulses(1'b1, 8'd3, 8'd1, 4'd1);
    repeat (3) @(posedge clk);
    rdc(8'h70, 32'h0);
    rdc(8'h78, 32'h3);
    rdc(8'h80, 32'h1);
    check(ev_n[2], 1);
    $display("test symbol period done");
    // errored frames and errored seconds over a one second window
    apb(1'b1, 8'h00, 32'ha);
    apb(1'b1, 8'h20, 32'ha);
    start(32'h3);
    u_lom_peer.pulses(1'b0, 8'd2, 8'd2, 4'd0);
    repeat (120) @(posedge clk);
    rdc(8'h48, 32'h0);
    rdc(8'h4c, 32'h2);
    rdc(8'h54, 32'h1);
    rdc(8'h88, 32'h0);
    rdc(8'h8c, 32'h1);
    rdc(8'h90, 32'h1);
    check({ev_n[0], ev_n[3]}, {32'd1, 32'd1});
    apb(1'b0, 8'h44, 32'h0);
    check(rd >= 32'd9 && rd <= 32'd10, 1'b1);
    $display("test time windows done");
    // sublayer clear, then counting refused while disabled
    oam_rst <= 1'b1;
    @(posedge clk);
    oam_rst <= 1'b0;
    repeat (2) @(posedge clk);
    rdc(8'h4c, 32'h0);
    rdc(8'h40, 32'h0);
    start(32'h0);
    u_lom_peer.pulses(1'b0, 8'd3, 8'd3, 4'd0);
    repeat (3) @(posedge clk);
    rdc(8'h4c, 32'h0);
    $display("test clear and disable done");
    // board reset in mid-run brings the configuration back to defaults
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc(8'h08, 32'h000003e8);
    rdc(8'h28, 32'h00000001);
    rdc(8'h18, 32'h00000001);
    $display("test mid-run reset done");
    test_done;
  end
endmodule
